/* File: analog_setup_cmd.sv */
// Analog setup command decoder with its Wishbone register port.
// Assumes command bytes and state flags come from logic on clk_i.
//
// What this block does
// - Two-byte command; byte one 000001 plus class and filter, byte two fields.
// - Command ignored if powered down, in power transitions, or playing when byte two arrives.
// - Sleep with analog powered up drops amplifiers at once, no quiet ramp.
// - All setup fields return to initial values on reset and sleep.
// - Class bit 0 selects class AB speaker output, 1 selects class D.
// - Filter bit 1 inserts 200Hz high-pass filter, 0 bypasses it.
// - Fade-on-halt bit 1 fades output on halt, 0 stops at once.
// - Channel-active-low held low during halt fade, high once fade completes.
// - DAC gain 00 off, 01 -6 dB, 10 0dB, 11 0dB but prohibited.
// - Mix gains apply only in speaker mode with class AB selected.
// - External gain 00 off, 01 -6 dB, 10 0dB, 11 0dB prohibited.
// - Quiet bit honoured only for line amplifier ramps, up or down.
// - Quiet ramps use quiet times, otherwise fast up and down times.
// - Speaker mode, line bit clear: speaker bit 0 powers down, 1 up.
// - Line mode, speaker bit clear: line bit 1 powers up, 0 down.
`timescale 1ns/1ns
module analog_setup_cmd #(
    parameter int QUIET_UP_US   = 100_000,
    parameter int QUIET_DOWN_US = 100_000,
    parameter int FAST_UP_US    = 10_000,
    parameter int FAST_DOWN_US  = 10_000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cmd_byte_valid_i,
    input  wire logic [7:0]  cmd_byte_i,
    input  wire logic        powered_down_i,
    input  wire logic        power_transition_i,
    input  wire logic        playing_i,
    input  wire logic        sleep_cmd_i,
    input  wire logic        halt_cmd_i,
    input  wire logic        fade_done_i,
    output logic             amp_class_select_o,
    output logic             bass_cut_filter_en_o,
    output logic             soft_halt_ramp_o,
    output logic [1:0]       dac_mix_gain_o,
    output logic [1:0]       ext_mix_gain_o,
    output logic             mix_gain_active_o,
    output logic             spk_amp_power_o,
    output logic             line_amp_power_o,
    output logic             ramp_active_o,
    output logic             ramp_up_o,
    output logic             cmd_accept_n_o,
    output logic             channel_active_n_o
);
    typedef enum logic [1:0] {S_IDLE, S_WAIT2, S_RAMP} state_t;

    localparam int W = asc_pkg::RAMP_W;
    localparam logic [W-1:0] QUIET_UP_T   = W'(QUIET_UP_US);
    localparam logic [W-1:0] QUIET_DOWN_T = W'(QUIET_DOWN_US);
    localparam logic [W-1:0] FAST_UP_T    = W'(FAST_UP_US);
    localparam logic [W-1:0] FAST_DOWN_T  = W'(FAST_DOWN_US);
    localparam logic [7:0]   TICK_MAX     = 8'(asc_pkg::TICK_CYCLES - 1);

    state_t       state_ff;
    state_t       nxt_state;
    logic [1:0]   first_ff;
    logic [1:0]   pend_ff;
    logic [7:0]   second_ff;
    logic [7:0]   tick_cnt_ff;
    logic         tick;
    logic         spk_on_ff;
    logic         line_on_ff;
    logic         ramp_up_ff;
    logic         accept_n_ff;
    logic         fading_ff;
    logic         ack_ff;
    logic [31:0]  rdata_ff;
    logic         bus_req;
    logic         bus_cmd_wr;
    logic         byte_valid;
    logic [7:0]   byte_val;
    logic         blocked;
    logic         take_second;
    logic         new_line;
    logic         new_spk;
    logic         new_quiet;
    logic         ramp_load;
    logic [W-1:0] ramp_val;
    logic         ramp_busy;
    logic         ramp_done;
    logic         line_mode;

    // Microsecond enable for the ramp timer
    always_ff @(posedge clk_i) begin
        if (rst_i || tick_cnt_ff == TICK_MAX) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end
    assign tick = (tick_cnt_ff == TICK_MAX);

    // Wishbone slave: one wait state, ack for one cycle
    assign bus_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    assign bus_cmd_wr = bus_req && wb_we_i && wb_sel_i[0]
                        && wb_adr_i == asc_pkg::REG_CMD;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                asc_pkg::REG_CMD:    rdata_ff <= {24'h000000, byte_val};
                asc_pkg::REG_STATUS: begin
                    rdata_ff <= 32'h0000_0000;
                    rdata_ff[asc_pkg::ST_ACCEPT_N] <= accept_n_ff;
                    rdata_ff[asc_pkg::ST_ACTIVE_N] <= !fading_ff;
                    rdata_ff[asc_pkg::ST_SPK_ON]   <= spk_on_ff;
                    rdata_ff[asc_pkg::ST_LINE_ON]  <= line_on_ff;
                    rdata_ff[asc_pkg::ST_RAMP]     <= ramp_busy;
                    rdata_ff[asc_pkg::ST_RAMP_UP]  <= ramp_up_ff;
                    rdata_ff[asc_pkg::ST_WAIT2]    <= (state_ff == S_WAIT2);
                end
                asc_pkg::REG_SETUP:  rdata_ff <= {22'h000000, first_ff,
                                                  second_ff};
                default:             rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // Serial bytes win over a bus-injected byte in the same cycle
    assign byte_valid = cmd_byte_valid_i || bus_cmd_wr;
    assign byte_val   = cmd_byte_valid_i ? cmd_byte_i : wb_dat_i[7:0];

    assign blocked = powered_down_i || power_transition_i || playing_i;
    assign take_second = (state_ff == S_WAIT2) && byte_valid && !blocked;

    // Line bit takes precedence if both power bits are set
    assign new_line  = byte_val[asc_pkg::B2_LINE];
    assign new_spk   = byte_val[asc_pkg::B2_SPK] && !new_line;
    assign new_quiet = byte_val[asc_pkg::B2_QUIET] && new_line;

    // Ramp length picked by the mode being left or entered
    always_comb begin
        ramp_load = 1'b0;
        ramp_val  = FAST_UP_T;
        if (take_second) begin
            if (new_line != line_on_ff) begin
                ramp_load = 1'b1;
                // Quiet bit of the new command governs power-down too
                if (new_line) begin
                    ramp_val = new_quiet ? QUIET_UP_T : FAST_UP_T;
                end else begin
                    ramp_val = byte_val[asc_pkg::B2_QUIET] ? QUIET_DOWN_T
                                                           : FAST_DOWN_T;
                end
            end else if (new_spk != spk_on_ff) begin
                ramp_load = 1'b1;
                ramp_val  = new_spk ? FAST_UP_T : FAST_DOWN_T;
            end
        end
    end

    ramp_timer #(
        .W (W)
    ) u_ramp (
        .clk_i      (clk_i),
        .rst_i      (rst_i || sleep_cmd_i),
        .tick_i     (tick),
        .load_i     (ramp_load),
        .load_val_i (ramp_val),
        .busy_o     (ramp_busy),
        .done_o     (ramp_done)
    );

    // Command sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (byte_valid
                    && byte_val[7:2] == asc_pkg::OPC_ANALOG_SETUP) begin
                    nxt_state = S_WAIT2;
                end
            end
            S_WAIT2: begin
                if (byte_valid) begin
                    nxt_state = ramp_load ? S_RAMP : S_IDLE;
                end
            end
            S_RAMP: begin
                if (ramp_done) begin
                    nxt_state = S_IDLE;
                end
            end
        endcase
        if (sleep_cmd_i) begin
            nxt_state = S_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Host must hold off while low; bytes sent then are not guarded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accept_n_ff <= 1'b1;
        end else begin
            accept_n_ff <= (nxt_state != S_RAMP);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_ff <= asc_pkg::RST_FIRST;
        end else if (state_ff == S_IDLE && byte_valid) begin
            pend_ff <= byte_val[1:0];
        end
    end

    // Fields are only committed when the second byte is accepted
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_cmd_i) begin
            first_ff  <= asc_pkg::RST_FIRST;
            second_ff <= asc_pkg::RST_SECOND;
        end else if (take_second) begin
            first_ff  <= pend_ff;
            second_ff <= byte_val;
        end
    end

    // Power state follows acceptance; sleep drops it with no ramp
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_cmd_i) begin
            spk_on_ff  <= 1'b0;
            line_on_ff <= 1'b0;
            ramp_up_ff <= 1'b0;
        end else if (take_second) begin
            spk_on_ff  <= new_spk;
            line_on_ff <= new_line;
            if (ramp_load) begin
                ramp_up_ff <= (new_line != line_on_ff) ? new_line : new_spk;
            end
        end
    end

    // Halt fade: set wins over the completion pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_cmd_i) begin
            fading_ff <= 1'b0;
        end else if (halt_cmd_i && second_ff[asc_pkg::B2_FADE]) begin
            fading_ff <= 1'b1;
        end else if (fade_done_i) begin
            fading_ff <= 1'b0;
        end
    end

    function automatic logic [1:0] gain_map(input logic [1:0] code);
        gain_map = (code == asc_pkg::GAIN_BANNED) ? asc_pkg::GAIN_0DB
                                                  : code;
    endfunction

    assign line_mode = second_ff[asc_pkg::B2_LINE];

    // Registered copies of the settings for the analog section
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_class_select_o   <= 1'b0;
            bass_cut_filter_en_o <= 1'b0;
            soft_halt_ramp_o     <= 1'b0;
            dac_mix_gain_o       <= asc_pkg::GAIN_OFF;
            ext_mix_gain_o       <= asc_pkg::GAIN_OFF;
            mix_gain_active_o    <= 1'b0;
            spk_amp_power_o      <= 1'b0;
            line_amp_power_o     <= 1'b0;
            ramp_active_o        <= 1'b0;
            ramp_up_o            <= 1'b0;
            channel_active_n_o   <= 1'b1;
        end else begin
            amp_class_select_o   <= first_ff[asc_pkg::B1_CLASS];
            bass_cut_filter_en_o <= first_ff[asc_pkg::B1_FILTER];
            soft_halt_ramp_o     <= second_ff[asc_pkg::B2_FADE];
            dac_mix_gain_o       <= gain_map(second_ff[6:5]);
            ext_mix_gain_o       <= gain_map(second_ff[4:3]);
            mix_gain_active_o    <= !first_ff[asc_pkg::B1_CLASS]
                                    && !line_mode;
            spk_amp_power_o      <= spk_on_ff;
            line_amp_power_o     <= line_on_ff;
            ramp_active_o        <= ramp_busy;
            ramp_up_o            <= ramp_up_ff;
            channel_active_n_o   <= !fading_ff;
        end
    end
    assign cmd_accept_n_o = accept_n_ff;

    a_wb_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_blocked_ignored: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == S_WAIT2 && byte_valid && blocked && !sleep_cmd_i)
        |=> $stable(second_ff) && $stable(first_ff) && state_ff == S_IDLE)
        else $error("setup accepted while blocked");

    a_sleep_clears: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sleep_cmd_i |=> second_ff == asc_pkg::RST_SECOND
                        && first_ff == asc_pkg::RST_FIRST
                        ##1 !amp_class_select_o && !soft_halt_ramp_o)
        else $error("sleep did not restore setup");

    a_sleep_no_ramp: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sleep_cmd_i |=> !ramp_busy && !spk_on_ff && !line_on_ff
                        ##1 !spk_amp_power_o && !line_amp_power_o)
        else $error("sleep left amplifiers powered");

    a_class_filter: assert property (
        @(posedge clk_i) disable iff (rst_i)
        take_second && !sleep_cmd_i |=> ##1
        amp_class_select_o == $past(pend_ff[1], 2)
        && bass_cut_filter_en_o == $past(pend_ff[0], 2))
        else $error("class or filter output wrong");

    a_gain_map: assert property (
        @(posedge clk_i) disable iff (rst_i)
        second_ff[6:5] == asc_pkg::GAIN_BANNED
        |=> dac_mix_gain_o == asc_pkg::GAIN_0DB)
        else $error("prohibited gain not mapped to 0dB");

    a_mix_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (first_ff[asc_pkg::B1_CLASS] || line_mode) |=> !mix_gain_active_o)
        else $error("mix gains active outside speaker class AB");

    a_fade_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (halt_cmd_i && second_ff[asc_pkg::B2_FADE] && !sleep_cmd_i)
        |=> ##1 !channel_active_n_o)
        else $error("channel active not held low on fade");

    a_quiet_len: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ramp_load && new_line && !line_on_ff && !sleep_cmd_i)
        |-> ramp_val == (byte_val[0] ? QUIET_UP_T : FAST_UP_T))
        else $error("line power-up ramp length wrong");

    a_spk_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ramp_load && !new_line && !line_on_ff && new_spk)
        |-> ramp_val == FAST_UP_T)
        else $error("quiet bit honoured in speaker mode");

    a_accept_ramp: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ramp_load && !sleep_cmd_i) |=> !cmd_accept_n_o && state_ff == S_RAMP)
        else $error("accept line not low during ramp");
endmodule

/* File: asc_pkg.sv */
// Constants for the analog setup command decoder.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
package asc_pkg;
    // Command encoding
    localparam logic [5:0] OPC_ANALOG_SETUP = 6'h01;
    localparam int         B1_CLASS         = 1;
    localparam int         B1_FILTER        = 0;
    localparam int         B2_FADE          = 7;
    localparam int         B2_DAC_HI        = 6;
    localparam int         B2_DAC_LO        = 5;
    localparam int         B2_EXT_HI        = 4;
    localparam int         B2_EXT_LO        = 3;
    localparam int         B2_LINE          = 2;
    localparam int         B2_SPK           = 1;
    localparam int         B2_QUIET         = 0;
    // Initial values after reset release or sleep
    localparam logic [1:0] RST_FIRST        = 2'h0;
    localparam logic [7:0] RST_SECOND       = 8'h00;
    // Mix gain codes
    localparam logic [1:0] GAIN_OFF         = 2'h0;
    localparam logic [1:0] GAIN_M6DB        = 2'h1;
    localparam logic [1:0] GAIN_0DB         = 2'h2;
    localparam logic [1:0] GAIN_BANNED      = 2'h3;
    // Register map (byte addresses)
    localparam logic [7:0] REG_CMD          = 8'h00;
    localparam logic [7:0] REG_STATUS       = 8'h04;
    localparam logic [7:0] REG_SETUP        = 8'h08;
    // Status field positions
    localparam int         ST_ACCEPT_N      = 0;
    localparam int         ST_ACTIVE_N      = 1;
    localparam int         ST_SPK_ON        = 2;
    localparam int         ST_LINE_ON       = 3;
    localparam int         ST_RAMP          = 4;
    localparam int         ST_RAMP_UP       = 5;
    localparam int         ST_WAIT2         = 6;
    // Timing
    localparam int         CLK_HZ           = 100_000_000;
    localparam int         TICK_NS          = 1000;
    localparam int         TICK_CYCLES      = TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam int         RAMP_W           = 20;
endpackage

/* File: host_model.sv */
// Host controller model driving the serial command byte port.
// Assumes the decoder samples bytes on the rising edge of clk_i.
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk_i,
    input  wire logic       cmd_accept_n_i,
    output logic            valid_o,
    output logic      [7:0] byte_o
);
    initial begin
        valid_o = 1'b0;
        byte_o  = 8'h00;
    end
    // Idle byte shows the inverse, so a stale copy never looks valid
    task automatic send(input logic [7:0] b1, input logic [7:0] b2,
                        input int gap);
        while (cmd_accept_n_i !== 1'b1) @(posedge clk_i);
        valid_o <= 1'b1;
        byte_o  <= b1;
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o  <= ~b1;
        repeat (gap + 1) @(posedge clk_i);
        valid_o <= 1'b1;
        byte_o  <= b2;
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o  <= ~b2;
    endtask
endmodule

/* File: ramp_timer.sv */
// Down counter timing one amplifier power ramp in microsecond ticks.
// Assumes tick_i is a one-cycle enable on the same clock.
`timescale 1ns/1ns
module ramp_timer #(
    parameter int W = 20
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    output logic              busy_o,
    output logic              done_o
);
    logic [W-1:0] count_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (load_i) begin
            count_ff <= (load_val_i == '0) ? W'(1) : load_val_i;
        end else if (tick_i && count_ff != '0) begin
            count_ff <= count_ff - W'(1);
        end
    end

    assign busy_o = (count_ff != '0);
    assign done_o = tick_i && (count_ff == W'(1)) && !load_i;
endmodule

/* File: testbench.sv */
// Self-checking bench for the analog setup command decoder.
// Assumes host_model on the byte port and this bench as bus master.
`timescale 1ns/1ns
module testbench;
    localparam int QU = 3;
    localparam int QD = 5;
    localparam int FU = 2;
    localparam int FD = 2;
    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [7:0]  wb_adr_i  = 8'h00;
    logic [31:0] wb_dat_i  = 32'h0;
    logic [3:0]  wb_sel_i  = 4'h0;
    logic [2:0]  blk       = 3'h0;
    logic [2:0]  ev        = 3'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cmd_byte_valid_i;
    logic [7:0]  cmd_byte_i;
    logic        cls, filt, fade, mix, spk, line, ract, rup, acc_n, act_n;
    logic [1:0]  dac, ext;
    logic [31:0] q;
    int          n, err_total, cmp_count, cyc_count;
    wire  [7:0]  settings = {cls, filt, fade, dac, ext, mix};
    // Rows: first byte, second byte, expected settings
    logic [7:0]  t_b1 [5] = '{8'h04, 8'h07, 8'h05, 8'h06, 8'h04};
    logic [7:0]  t_b2 [5] = '{8'hA8, 8'h50, 8'h78, 8'h00, 8'h00};
    logic [7:0]  t_ex [5] = '{8'h2B, 8'hD4, 8'h55, 8'h80, 8'h01};
    // Power rows: second byte, ramp length in us, {spk, line, up, mix}
    logic [7:0]  p_b2 [6] = '{8'h05, 8'h01, 8'h04, 8'h00, 8'h03, 8'h00};
    int          p_us [6] = '{QU, QD, FU, FD, FU, FD};
    logic [3:0]  p_ex [6] = '{4'h6, 4'h1, 4'h6, 4'h1, 4'hB, 4'h1};

    analog_setup_cmd #(.QUIET_UP_US(QU), .QUIET_DOWN_US(QD),
        .FAST_UP_US(FU), .FAST_DOWN_US(FD)) analog_setup_cmd_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmd_byte_valid_i(cmd_byte_valid_i),
        .cmd_byte_i(cmd_byte_i), .powered_down_i(blk[0]),
        .power_transition_i(blk[1]), .playing_i(blk[2]),
        .sleep_cmd_i(ev[0]), .halt_cmd_i(ev[1]), .fade_done_i(ev[2]),
        .amp_class_select_o(cls), .bass_cut_filter_en_o(filt),
        .soft_halt_ramp_o(fade), .dac_mix_gain_o(dac),
        .ext_mix_gain_o(ext), .mix_gain_active_o(mix),
        .spk_amp_power_o(spk), .line_amp_power_o(line),
        .ramp_active_o(ract), .ramp_up_o(rup), .cmd_accept_n_o(acc_n),
        .channel_active_n_o(act_n));
    host_model host_model_inst (.clk_i(clk_i), .cmd_accept_n_i(acc_n),
        .valid_o(cmd_byte_valid_i), .byte_o(cmd_byte_i));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk_i);
        ev[k] <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // Request held until ack is sampled high, then released
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(settings[7:1] === 7'h00 && {spk, line, ract, acc_n, act_n}
              === 5'h03, "reset values");
        for (int i = 0; i < 5; i++) begin
            host_model_inst.send(t_b1[i], t_b2[i], i);
            repeat (3) @(posedge clk_i);
            check(settings === t_ex[i], "field decode");
        end
        for (int i = 0; i < 3; i++) begin
            blk[i] <= 1'b1;
            host_model_inst.send(8'h07, 8'hA8, 0);
            repeat (3) @(posedge clk_i);
            check(settings === 8'h01, "blocked command taken");
            blk[i] <= 1'b0;
        end
        host_model_inst.send(8'h0C, 8'hA8, 0);
        repeat (3) @(posedge clk_i);
        check(settings === 8'h01, "foreign opcode taken");
        // Class AB kept and channel gain at zero before power-up
        for (int i = 0; i < 6; i++) begin
            host_model_inst.send(8'h04, p_b2[i], 0);
            repeat (2) @(posedge clk_i);
            check(ract === 1'b1 && acc_n === 1'b0, "ramp start");
            n = 0;
            while (acc_n === 1'b0 && n < 2000) begin
                @(posedge clk_i);
                n++;
            end
            // Tick phase makes the ramp end within the last microsecond
            check(n >= p_us[i] * 100 - 100 && n < p_us[i] * 100,
                  "ramp length");
            check({spk, line, rup, mix} === p_ex[i], "power state");
        end
        host_model_inst.send(8'h05, 8'hA2, 0);
        repeat (50) @(posedge clk_i);
        pulse(0);
        check(settings[7:1] === 7'h00 && {spk, ract, acc_n} === 3'h1,
              "sleep clear");
        host_model_inst.send(8'h04, 8'h80, 3);
        repeat (3) @(posedge clk_i);
        pulse(1);
        repeat (8) @(posedge clk_i);
        check(act_n === 1'b0, "fade hold");
        pulse(2);
        check(act_n === 1'b1, "fade end");
        host_model_inst.send(8'h04, 8'h00, 0);
        repeat (3) @(posedge clk_i);
        pulse(1);
        check(act_n === 1'b1, "halt without fade");
        wb(1'b1, 8'h00, 32'h05, q);
        wb(1'b1, 8'h00, 32'h40, q);
        repeat (3) @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0, q);
        check(q[9:0] === 10'h140 && dac === 2'h2, "bus command");
        wb(1'b1, 8'h20, 32'hFF, q);
        wb(1'b0, 8'h20, 32'h0, q);
        check(q === 32'h0, "unmapped read");
        wb(1'b0, 8'h04, 32'h0, q);
        check(q[1:0] === 2'h3, "status idle");
        summarize();
    end
endmodule
